// [crr_pkg.sv]
// Constants, field layouts and carrier types for the CPU reset and core register block.
// Assumes a single 50 MHz CPU clock domain.
`default_nettype none
package crr_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int PIN_FILTER_NS = 5000;
    localparam int PIN_FILTER_CYC = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_HOLD_NS = 50000;
    localparam int PIN_HOLD_CYC = (PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SP = 8'h81;
    localparam logic [7:0] OFS_STACK_HI = 8'h9B;
    localparam logic [7:0] OFS_ACON = 8'h9D;
    localparam logic [7:0] OFS_STATUS = 8'hC5;
    localparam logic [7:0] OFS_PSW = 8'hD0;
    localparam logic [7:0] OFS_ACC = 8'hE0;
    localparam logic [7:0] OFS_B = 8'hF0;
    localparam logic [7:0] OFS_RSTCTRL = 8'hFE;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [19:0] PC_RESET_VECTOR = 20'h07000;
    localparam int CTRL_LOWSUP_EN = 0;
    localparam int CTRL_DOG_EN = 1;
    localparam int CTRL_DOG_SEL_LO = 2;
    localparam int CTRL_DOG_SEL_HI = 3;
    localparam int CTRL_CLK_EXT = 4;
    localparam logic [7:0] CTRL_WR_MASK = 8'h1F;
    localparam logic [1:0] DOG_SEL_MAX = 2'h3;
    localparam logic [7:0] CTRL_RESET = 8'h0E;
    localparam int ACON_AM_LO = 0;
    localparam int ACON_AM_HI = 1;
    localparam int ACON_SA = 2;
    localparam logic [7:0] STATUS_MASK = 8'h6F;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic carryFlag;
        logic auxCarryFlag;
        logic generalFlag;
        logic [1:0] bankSelect;
        logic overflowFlag;
        logic userFlag;
        logic parityFlag;
    } crr_psw_t;

    typedef struct packed {
        logic rsvd7;
        logic highPrioActive;
        logic lowPrioActive;
        logic rsvd4;
        logic serial1TxActive;
        logic serial1RxActive;
        logic serial0TxActive;
        logic serial0RxActive;
    } crr_status_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic wrEn;
        logic rdEn;
    } crr_stack_t;
endpackage
`default_nettype wire

// [crr_core.sv]
// Reset gathering, post-reset defaults and core register set of the CPU.
// Assumes supply detectors and reset pin are asynchronous; all other inputs are on ref_clk.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module crr_core #(
    parameter int FILTER_CYC = crr_pkg::PIN_FILTER_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Reset sources and reset pin
    input wire logic extResetPinIn,
    output logic extResetPinOut,
    output logic extResetPinOe,
    input wire logic supplyLossIn,
    input wire logic lowSupplyDetIn,
    input wire logic dogTimeoutIn,
    // Post-reset state
    output logic sysResetOut,
    output logic [19:0] pcResetVector,
    output logic dogResetEnable,
    output logic [1:0] dogTimeoutSel,
    output logic clkSelInternal,
    input wire logic stopSleepMode,
    output logic intOscEnable,
    // Activity sources
    input wire crr_pkg::crr_status_t activityIn,
    // Stack access
    input wire logic stackPush,
    input wire logic stackPop,
    input wire logic [7:0] stackRdData,
    output crr_pkg::crr_stack_t stackOut,
    // Core register views
    output logic [7:0] accOut,
    output logic [7:0] bOut,
    output crr_pkg::crr_psw_t pswOut,
    output logic wideAddrMode,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData
);
    localparam int CW = $clog2(FILTER_CYC + 1);

    logic pinMeta_q;
    logic pinSync_q;
    logic supplyMeta_q;
    logic supplySync_q;
    logic lowDetMeta_q;
    logic lowDetSync_q;
    logic [CW-1:0] pinLowCnt_q;
    logic pinReset;
    logic lowSupplyReset;
    logic sysReset_q;
    logic [7:0] ctrl_q;
    logic [1:0] addrMode_q;
    logic [7:0] acc_q;
    logic [7:0] b_q;
    logic [7:0] psw_q;
    logic [7:0] sp_q;
    logic [7:0] stackHi_q;
    logic [7:0] regRdData_q;
    logic [7:0] rdMux;
    logic [7:0] statusLive;
    logic wide;
    logic [15:0] pushAddr;
    logic [15:0] popAddr;
    logic [15:0] stackNext;
    logic doPush;
    logic doPop;
    logic wrSp;
    logic wrStackHi;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinMeta_q <= 1'b1;
            pinSync_q <= 1'b1;
            supplyMeta_q <= 1'b0;
            supplySync_q <= 1'b0;
            lowDetMeta_q <= 1'b0;
            lowDetSync_q <= 1'b0;
        end else begin
            pinMeta_q <= extResetPinIn;
            pinSync_q <= pinMeta_q;
            supplyMeta_q <= supplyLossIn;
            supplySync_q <= supplyMeta_q;
            lowDetMeta_q <= lowSupplyDetIn;
            lowDetSync_q <= lowDetMeta_q;
        end
    end

    // ------------------------------------------------------------
    // Reset pin filter
    // ------------------------------------------------------------
    // Any high sample restarts the count, so only an unbroken low counts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinLowCnt_q <= '0;
        end else if (pinSync_q) begin
            pinLowCnt_q <= '0;
        end else if (!pinReset) begin
            pinLowCnt_q <= pinLowCnt_q + 1'b1;
        end
    end

    assign pinReset = (pinLowCnt_q == CW'(FILTER_CYC));

    a_filter_len: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pinReset) |-> $past(!pinSync_q) && $past(pinLowCnt_q) == CW'(FILTER_CYC - 1))
        else $error("pin reset taken before the filter time");

    // ------------------------------------------------------------
    // Reset gathering
    // ------------------------------------------------------------
    assign lowSupplyReset = lowDetSync_q && ctrl_q[crr_pkg::CTRL_LOWSUP_EN];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sysReset_q <= 1'b1;
        end else begin
            sysReset_q <= pinReset || supplySync_q || lowSupplyReset || dogTimeoutIn;
        end
    end

    // The pin is pulled low from inside so the filter keeps the reset going
    assign extResetPinOut = 1'b0;
    assign extResetPinOe = supplySync_q || lowSupplyReset;
    assign sysResetOut = sysReset_q;
    assign pcResetVector = crr_pkg::PC_RESET_VECTOR;

    a_reset_cause: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(sysReset_q) |-> $past(pinReset || supplySync_q || lowSupplyReset || dogTimeoutIn))
        else $error("system reset without a source");

    a_dog_reset: assert property (@(posedge ref_clk) disable iff (rst)
        dogTimeoutIn |=> sysReset_q)
        else $error("watchdog timeout did not reset");

    a_pin_drive: assert property (@(posedge ref_clk) disable iff (rst)
        supplySync_q |-> extResetPinOe && !extResetPinOut)
        else $error("supply loss not driving reset pin low");

    // ------------------------------------------------------------
    // Reset, clock and address mode control
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= crr_pkg::CTRL_RESET;
        end else if (sysReset_q) begin
            ctrl_q <= crr_pkg::CTRL_RESET;
        end else if (regWr && regAddr == crr_pkg::OFS_RSTCTRL) begin
            ctrl_q <= regWrData & crr_pkg::CTRL_WR_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addrMode_q <= 2'h0;
        end else if (sysReset_q) begin
            addrMode_q <= 2'h0;
        end else if (regWr && regAddr == crr_pkg::OFS_ACON) begin
            addrMode_q <= regWrData[crr_pkg::ACON_AM_HI:crr_pkg::ACON_AM_LO];
        end
    end

    assign wide = addrMode_q[1];
    assign wideAddrMode = wide;
    assign dogResetEnable = ctrl_q[crr_pkg::CTRL_DOG_EN];
    assign dogTimeoutSel = ctrl_q[crr_pkg::CTRL_DOG_SEL_HI:crr_pkg::CTRL_DOG_SEL_LO];
    assign clkSelInternal = !ctrl_q[crr_pkg::CTRL_CLK_EXT];
    assign intOscEnable = !stopSleepMode;

    a_dog_armed: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(sysReset_q) |-> dogResetEnable && dogTimeoutSel == crr_pkg::DOG_SEL_MAX
            && clkSelInternal)
        else $error("watchdog or clock select wrong after reset");

    a_lowsup_off: assert property (@(posedge ref_clk) disable iff (rst)
        $past(sysReset_q) |-> !ctrl_q[crr_pkg::CTRL_LOWSUP_EN])
        else $error("low-supply reset enabled after reset");

    a_lowsup_fires: assert property (@(posedge ref_clk) disable iff (rst)
        (lowDetSync_q && ctrl_q[crr_pkg::CTRL_LOWSUP_EN]) |-> extResetPinOe ##1 sysReset_q)
        else $error("enabled low-supply detector did not reset");

    a_osc_mode: assert property (@(posedge ref_clk) disable iff (rst)
        intOscEnable != stopSleepMode)
        else $error("oscillator state wrong for mode");

    // ------------------------------------------------------------
    // Stack addressing
    // ------------------------------------------------------------
    // Narrow mode wraps inside the 256-byte internal memory
    assign pushAddr = wide ? {stackHi_q, sp_q} + 16'h0001 : {8'h00, sp_q + 8'h01};
    assign popAddr = wide ? {stackHi_q, sp_q} : {8'h00, sp_q};
    assign doPush = stackPush && !sysReset_q;
    assign doPop = stackPop && !stackPush && !sysReset_q;
    assign stackNext = doPush ? pushAddr : popAddr - 16'h0001;
    assign wrSp = regWr && regAddr == crr_pkg::OFS_SP;
    assign wrStackHi = regWr && regAddr == crr_pkg::OFS_STACK_HI;

    always_comb begin
        stackOut.addr = doPush ? pushAddr : popAddr;
        stackOut.data = acc_q;
        stackOut.wrEn = doPush;
        stackOut.rdEn = doPop;
    end

    // A register write in the same cycle takes precedence over the stack move
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sp_q <= crr_pkg::BYTE_RESET;
        end else if (sysReset_q) begin
            sp_q <= crr_pkg::BYTE_RESET;
        end else if (wrSp) begin
            sp_q <= regWrData;
        end else if (doPush || doPop) begin
            sp_q <= stackNext[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stackHi_q <= crr_pkg::BYTE_RESET;
        end else if (sysReset_q) begin
            stackHi_q <= crr_pkg::BYTE_RESET;
        end else if (wrStackHi) begin
            stackHi_q <= regWrData;
        end else if (wide && (doPush || doPop)) begin
            stackHi_q <= stackNext[15:8];
        end
    end

    a_push_addr: assert property (@(posedge ref_clk) disable iff (rst)
        (doPush && !wrSp && !wide) |-> stackOut.wrEn && stackOut.data == acc_q
            && stackOut.addr[7:0] == sp_q + 8'h01 ##1 sp_q == $past(stackOut.addr[7:0])
            && sp_q == $past(sp_q) + 8'h01)
        else $error("push address or pointer step wrong");

    a_wide_stack: assert property (@(posedge ref_clk) disable iff (rst)
        (doPush && wide && !wrSp && !wrStackHi) |=>
            {stackHi_q, sp_q} == $past({stackHi_q, sp_q}) + 16'h0001)
        else $error("wide stack pointer step wrong");

    // ------------------------------------------------------------
    // Accumulator, aux operand, status word
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_q <= crr_pkg::BYTE_RESET;
        end else if (sysReset_q) begin
            acc_q <= crr_pkg::BYTE_RESET;
        end else if (regWr && regAddr == crr_pkg::OFS_ACC) begin
            acc_q <= regWrData;
        end else if (doPop) begin
            acc_q <= stackRdData;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            b_q <= crr_pkg::BYTE_RESET;
        end else if (sysReset_q) begin
            b_q <= crr_pkg::BYTE_RESET;
        end else if (regWr && regAddr == crr_pkg::OFS_B) begin
            b_q <= regWrData;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            psw_q <= crr_pkg::BYTE_RESET;
        end else if (sysReset_q) begin
            psw_q <= crr_pkg::BYTE_RESET;
        end else if (regWr && regAddr == crr_pkg::OFS_PSW) begin
            psw_q <= regWrData;
        end
    end

    assign accOut = acc_q;
    assign bOut = b_q;
    assign pswOut = crr_pkg::crr_psw_t'(psw_q);

    a_pop_load: assert property (@(posedge ref_clk) disable iff (rst)
        (doPop && !(regWr && regAddr == crr_pkg::OFS_ACC)) |-> stackOut.rdEn
            && stackOut.addr == popAddr ##1 acc_q == $past(stackRdData))
        else $error("pop did not load accumulator");

    a_reset_defaults: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(sysReset_q) |-> acc_q == 8'h00 && b_q == 8'h00 && psw_q == 8'h00
            && sp_q == 8'h00 && stackHi_q == 8'h00 && !wide)
        else $error("register not at default after reset");

    // ------------------------------------------------------------
    // Activity status and read port
    // ------------------------------------------------------------
    // Sampled straight from the sources; nothing to clear
    assign statusLive = activityIn & crr_pkg::STATUS_MASK;

    always_comb begin
        case (regAddr)
            crr_pkg::OFS_SP: rdMux = sp_q;
            crr_pkg::OFS_STACK_HI: rdMux = stackHi_q;
            crr_pkg::OFS_ACON: rdMux = {5'h00, wide, addrMode_q};
            crr_pkg::OFS_STATUS: rdMux = statusLive;
            crr_pkg::OFS_PSW: rdMux = psw_q;
            crr_pkg::OFS_ACC: rdMux = acc_q;
            crr_pkg::OFS_B: rdMux = b_q;
            crr_pkg::OFS_RSTCTRL: rdMux = ctrl_q;
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData_q <= 8'h00;
        end else begin
            regRdData_q <= regRd ? rdMux : 8'h00;
        end
    end

    assign regRdData = regRdData_q;

    a_status_live: assert property (@(posedge ref_clk) disable iff (rst)
        (regRd && regAddr == crr_pkg::OFS_STATUS) |=>
            regRdData[6] == $past(activityIn.highPrioActive)
            && regRdData[5] == $past(activityIn.lowPrioActive)
            && regRdData[3:0] == $past(activityIn[3:0]) && regRdData[7] == 1'b0)
        else $error("activity read does not follow sources");
endmodule // crr_core
`default_nettype wire

// [crr_core_bench.sv]
// Self-checking bench for the CPU reset and core register block.
// Assumes crr_pkg and crr_core are compiled first; the bench drives every port itself.
`timescale 1ns/1ns
`default_nettype none
module crr_core_bench;
    // ----------------
    // Stimulus and wires
    // ----------------
    // Short filter keeps the pin scenarios brief
    localparam int FILT = 8;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic pinBtn = 1'b1;
    logic supplyLossIn = 1'b0;
    logic lowSupplyDetIn = 1'b0;
    logic dogTimeoutIn = 1'b0;
    logic stopSleepMode = 1'b0;
    crr_pkg::crr_status_t activityIn = '0;
    logic stackPush = 1'b0;
    logic stackPop = 1'b0;
    logic [7:0] stackRdData = 8'h00;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic extResetPinOut, extResetPinOe, sysResetOut, dogResetEnable, clkSelInternal;
    logic intOscEnable, wideAddrMode;
    logic [19:0] pcResetVector;
    logic [1:0] dogTimeoutSel;
    crr_pkg::crr_stack_t stackOut;
    logic [7:0] accOut, bOut, regRdData;
    crr_pkg::crr_psw_t pswOut;
    wire pinWire;
    int fails = 0;
    int nTests = 0;
    logic [7:0] ofsList [8] = '{crr_pkg::OFS_SP, crr_pkg::OFS_STACK_HI, crr_pkg::OFS_STATUS,
        crr_pkg::OFS_PSW, crr_pkg::OFS_ACC, crr_pkg::OFS_B, crr_pkg::OFS_RSTCTRL,
        crr_pkg::OFS_ACON};
    logic [7:0] rstList [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h00};
    logic [7:0] actList [8] = '{8'hFF, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};

    // Pin has a pull-up; the block only ever pulls it low
    assign pinWire = extResetPinOe ? extResetPinOut : pinBtn;
    always #10 ref_clk = ~ref_clk;

    crr_core #(.FILTER_CYC(FILT)) uut (
        .ref_clk(ref_clk), .rst(rst), .extResetPinIn(pinWire),
        .extResetPinOut(extResetPinOut), .extResetPinOe(extResetPinOe),
        .supplyLossIn(supplyLossIn), .lowSupplyDetIn(lowSupplyDetIn),
        .dogTimeoutIn(dogTimeoutIn), .sysResetOut(sysResetOut),
        .pcResetVector(pcResetVector), .dogResetEnable(dogResetEnable),
        .dogTimeoutSel(dogTimeoutSel), .clkSelInternal(clkSelInternal),
        .stopSleepMode(stopSleepMode), .intOscEnable(intOscEnable),
        .activityIn(activityIn), .stackPush(stackPush), .stackPop(stackPop),
        .stackRdData(stackRdData), .stackOut(stackOut), .accOut(accOut), .bOut(bOut),
        .pswOut(pswOut), .wideAddrMode(wideAddrMode), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData)
    );

    // ----------------
    // Checks and access tasks
    // ----------------
    task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkBit(input string what, input logic exp, input logic got);
        checkByte(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic checkWide(input string what, input logic [19:0] exp, input logic [19:0] got);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic readCheck(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        checkByte(what, exp, regRdData);
    endtask
    // Bounded wait on system reset; running out ends the run
    task automatic waitLevel(input string what, input logic lvl, input int bound);
        int i;
        i = 0;
        while (sysResetOut !== lvl && i < bound) begin
            tick(1);
            i++;
        end
        checkBit(what, lvl, sysResetOut);
        if (sysResetOut !== lvl) print_verdict();
    endtask
    task automatic stackOp(input logic push, input logic [7:0] d, input logic [15:0] addr);
        @(posedge ref_clk);
        stackPush <= push;
        stackPop <= ~push;
        stackRdData <= d;
        #1;
        checkWide("stack addr", {4'h0, addr}, {4'h0, stackOut.addr});
        checkBit("stack write", push, stackOut.wrEn);
        checkBit("stack read", ~push, stackOut.rdEn);
        if (push) checkByte("stack data", d, stackOut.data);
        @(posedge ref_clk);
        stackPush <= 1'b0;
        stackPop <= 1'b0;
        #1;
        if (!push) checkByte("pop result", d, accOut);
    endtask
    task automatic armRegs;
        regWrite(crr_pkg::OFS_ACC, 8'h5A);
        regWrite(crr_pkg::OFS_RSTCTRL, 8'h10);
        checkBit("clock select", 1'b0, clkSelInternal);
    endtask
    task automatic afterReset;
        waitLevel("reset drop", 1'b0, 100);
        tick(2);
        readCheck("acc restored", crr_pkg::OFS_ACC, 8'h00);
        readCheck("control restored", crr_pkg::OFS_RSTCTRL, 8'h0E);
        checkBit("clock select", 1'b1, clkSelInternal);
        checkBit("dog enable", 1'b1, dogResetEnable);
    endtask

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        tick(3);
        for (int i = 0; i < 8; i++) readCheck("reset value", ofsList[i], rstList[i]);
        checkWide("pc vector", 20'h07000, pcResetVector);
        checkByte("dog timeout", 8'h03, {6'h00, dogTimeoutSel});
        for (int i = 0; i < 6; i++) regWrite(ofsList[i], 8'h91 + 8'(i));
        for (int i = 0; i < 6; i++) if (i != 2) readCheck("rw", ofsList[i], 8'h91 + 8'(i));
        readCheck("status ignores writes", crr_pkg::OFS_STATUS, 8'h00);
        readCheck("unmapped", 8'h55, 8'h00);
        checkByte("acc port", 8'h95, accOut);
        checkByte("b port", 8'h96, bOut);
        regWrite(crr_pkg::OFS_PSW, 8'h98);
        checkBit("carry", 1'b1, pswOut.carryFlag);
        checkByte("bank", 8'h03, {6'h00, pswOut.bankSelect});
        checkBit("parity", 1'b0, pswOut.parityFlag);
        // Activity must follow its sources live, so the last pattern clears it
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            activityIn <= actList[i];
            readCheck("activity", crr_pkg::OFS_STATUS, actList[i] & 8'h6F);
        end
        // Software side: activity must be idle before low power is entered
        readCheck("poll before sleep", crr_pkg::OFS_STATUS, 8'h00);
        @(posedge ref_clk);
        stopSleepMode <= 1'b1;
        tick(1);
        checkBit("osc in sleep", 1'b0, intOscEnable);
        @(posedge ref_clk);
        stopSleepMode <= 1'b0;
        tick(1);
        checkBit("osc running", 1'b1, intOscEnable);
        regWrite(crr_pkg::OFS_SP, 8'h07);
        regWrite(crr_pkg::OFS_ACC, 8'hA5);
        stackOp(1'b1, 8'hA5, 16'h0008);
        readCheck("sp after push", crr_pkg::OFS_SP, 8'h08);
        stackOp(1'b0, 8'h3C, 16'h0008);
        readCheck("sp after pop", crr_pkg::OFS_SP, 8'h07);
        regWrite(crr_pkg::OFS_SP, 8'hFF);
        regWrite(crr_pkg::OFS_STACK_HI, 8'h12);
        stackOp(1'b1, 8'h3C, 16'h0000);
        readCheck("narrow keeps high", crr_pkg::OFS_STACK_HI, 8'h12);
        regWrite(crr_pkg::OFS_ACON, 8'h02);
        checkBit("wide mode", 1'b1, wideAddrMode);
        readCheck("mode indicator", crr_pkg::OFS_ACON, 8'h06);
        regWrite(crr_pkg::OFS_SP, 8'hFF);
        stackOp(1'b1, 8'h3C, 16'h1300);
        readCheck("wide sp", crr_pkg::OFS_SP, 8'h00);
        readCheck("wide high", crr_pkg::OFS_STACK_HI, 8'h13);
        stackOp(1'b0, 8'h77, 16'h1300);
        readCheck("wide borrow", crr_pkg::OFS_STACK_HI, 8'h12);
        // Pin low just under the filter length must not reset
        armRegs();
        @(posedge ref_clk);
        pinBtn <= 1'b0;
        repeat (FILT - 2) @(posedge ref_clk);
        pinBtn <= 1'b1;
        tick(10);
        readCheck("short pin low", crr_pkg::OFS_ACC, 8'h5A);
        @(posedge ref_clk);
        pinBtn <= 1'b0;
        // Outside party keeps the pin low until the reset is seen taken
        waitLevel("pin reset", 1'b1, FILT + 6);
        @(posedge ref_clk);
        pinBtn <= 1'b1;
        afterReset();
        armRegs();
        @(posedge ref_clk);
        dogTimeoutIn <= 1'b1;
        @(posedge ref_clk);
        dogTimeoutIn <= 1'b0;
        #1;
        checkBit("dog reset", 1'b1, sysResetOut);
        afterReset();
        armRegs();
        @(posedge ref_clk);
        supplyLossIn <= 1'b1;
        waitLevel("supply reset", 1'b1, 6);
        tick(2);
        checkBit("supply pulls pin", 1'b1, extResetPinOe);
        checkBit("pin level", 1'b0, pinWire);
        @(posedge ref_clk);
        supplyLossIn <= 1'b0;
        afterReset();
        armRegs();
        @(posedge ref_clk);
        lowSupplyDetIn <= 1'b1;
        tick(10);
        checkBit("low supply disabled", 1'b0, sysResetOut);
        regWrite(crr_pkg::OFS_RSTCTRL, 8'h11);
        checkBit("low supply pulls pin", 1'b1, extResetPinOe);
        waitLevel("low supply reset", 1'b1, 8);
        @(posedge ref_clk);
        lowSupplyDetIn <= 1'b0;
        afterReset();
        print_verdict();
    end
endmodule // crr_core_bench
`default_nettype wire
